// file: hdl/nxa_datapath.sv
// Purpose: sequencer for exchange_digit and the six xor_bytes forms
// Assumes: memory port answers a read with data on the next cycle
// Notes: the accumulator is held here; status flags have no path out
`default_nettype none

module nxa_datapath
    import nxa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // instruction request
    input wire logic start_in,
    input wire logic [7:0] opcode_in,
    input wire logic [7:0] operand1_in,
    input wire logic [7:0] operand2_in,
    input wire logic [1:0] bank_in,
    // accumulator load from the core
    input wire logic acc_load_in,
    input wire logic [7:0] acc_data_in,
    // memory port
    input wire logic [7:0] mem_rdata_in,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_addr_out,
    output logic mem_indirect_out,
    output logic mem_latch_out,
    output logic [7:0] mem_wdata_out,
    // status
    output logic busy_out,
    output logic done_out,
    output logic illegal_out,
    output logic [7:0] acc_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_PTR,
        ST_RD_OPND,
        ST_EXEC,
        ST_WB
    } nxa_state_t;

    nxa_state_t state_reg, state_next;
    logic [7:0] op_reg;
    logic [7:0] dir_reg;
    logic [7:0] imm_reg;
    logic [7:0] addr_reg;
    logic [7:0] acc_reg;
    logic [7:0] wdata_reg;

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    wire logic idle = (state_reg == ST_IDLE);
    wire logic [7:0] op = idle ? opcode_in : op_reg;
    wire logic is_exdig = (op[7:1] == OPC_EXDIG_HI);
    wire logic is_xa_reg = (op[7:3] == OPC_XA_REG_HI);
    wire logic is_xa_ind = (op[7:1] == OPC_XA_IND_HI);
    wire logic is_xa_dir = (op == OPC_XA_DIR);
    wire logic is_xa_imm = (op == OPC_XA_IMM);
    wire logic is_xd_acc = (op == OPC_XD_ACC);
    wire logic is_xd_imm = (op == OPC_XD_IMM);
    wire logic is_xa = is_xa_reg | is_xa_ind | is_xa_dir | is_xa_imm;
    wire logic is_xd = is_xd_acc | is_xd_imm;
    wire logic indirect = is_exdig | is_xa_ind;
    wire logic legal = is_exdig | is_xa | is_xd;
    wire logic take = idle & start_in;
    wire nxa_kind_t kind = is_exdig ? NXA_KIND_EXDIG :
                           is_xd ? NXA_KIND_XOR_DIR : NXA_KIND_XOR_ACC;

    // --------------------------------------------------------------
    // addressing
    // --------------------------------------------------------------
    // the pointer and the bank registers live in the selected bank of the low RAM
    wire logic [7:0] ptr_addr = {BANK_BASE_HI, bank_in, 2'b00, op[0]};
    wire logic [7:0] reg_addr = {BANK_BASE_HI, bank_in, op[2:0]};
    wire logic [7:0] opnd_addr = indirect ? mem_rdata_in :
                                 is_xa_reg ? reg_addr : dir_reg;

    assign mem_rd_out = (state_reg == ST_RD_PTR) | (state_reg == ST_RD_OPND);
    assign mem_addr_out = (state_reg == ST_RD_PTR) ? ptr_addr :
                          (state_reg == ST_RD_OPND) ? opnd_addr : addr_reg;
    assign mem_indirect_out = indirect & ~idle;
    // read-modify-write of a port must see the latch, not the pin level
    assign mem_latch_out = (state_reg == ST_RD_OPND) & is_xd;
    assign mem_wr_out = (state_reg == ST_WB);
    assign mem_wdata_out = wdata_reg;

    // --------------------------------------------------------------
    // operand selection and result
    // --------------------------------------------------------------
    wire logic [7:0] src = is_xa_imm ? imm_reg :
                           is_xa ? mem_rdata_in :
                           is_xd_imm ? imm_reg : acc_reg;
    wire logic [7:0] acc_new;
    wire logic [7:0] mem_new;

    nxa_alu_core u_alu (
        .kind_in(kind),
        .acc_in(acc_reg),
        .mem_in(mem_rdata_in),
        .src_in(src),
        .acc_new_out(acc_new),
        .mem_new_out(mem_new)
    );

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take && legal) begin
                    state_next = indirect ? ST_RD_PTR : is_xa_imm ? ST_EXEC : ST_RD_OPND;
                end
            end
            ST_RD_PTR: state_next = ST_RD_OPND;
            ST_RD_OPND: state_next = ST_EXEC;
            ST_EXEC: state_next = is_xa ? ST_IDLE : ST_WB;
            ST_WB: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    wire logic exec = (state_reg == ST_EXEC);
    // immediate of the three-byte form sits in the second operand byte
    wire logic [7:0] imm_pick = is_xd_imm ? operand2_in : operand1_in;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (take) begin
            op_reg <= opcode_in;
            dir_reg <= operand1_in;
            imm_reg <= imm_pick;
        end
        if (state_reg == ST_RD_OPND) begin
            addr_reg <= opnd_addr;
        end
        if (exec) begin
            wdata_reg <= mem_new;
        end
    end

    // status flags are not part of this datapath and are never written
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            acc_reg <= ACC_RESET;
        end else if (exec && !is_xd) begin
            acc_reg <= acc_new;
        end else if (idle && acc_load_in) begin
            acc_reg <= acc_data_in;
        end
    end

    assign acc_out = acc_reg;
    assign busy_out = ~idle;
    assign done_out = (exec & is_xa) | mem_wr_out;
    assign illegal_out = take & ~legal;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    AST_EXDIG_LOW_SWAP: assert property (
        exec && is_exdig |=> acc_reg[3:0] == $past(mem_rdata_in[3:0])
            && mem_wr_out && mem_wdata_out[3:0] == $past(acc_reg[3:0]))
        else $error("exchange_digit low nibbles not swapped");

    AST_EXDIG_HIGH_KEEP: assert property (
        exec && is_exdig |=> $stable(acc_reg[7:4])
            && mem_wdata_out[7:4] == $past(mem_rdata_in[7:4]))
        else $error("exchange_digit disturbed a high nibble");

    AST_XA_RESULT: assert property (
        exec && is_xa |=> acc_reg == ($past(acc_reg) ^ $past(src)) && idle)
        else $error("xor into accumulator gave wrong result");

    AST_XA_NO_WRITE: assert property (
        take && legal && (opcode_in[7:3] == OPC_XA_REG_HI) |-> ##1 !mem_wr_out [*3])
        else $error("xor into accumulator wrote memory");

    AST_XA_REG_ADDR: assert property (
        take && (opcode_in[7:3] == OPC_XA_REG_HI)
            |=> mem_rd_out && mem_addr_out == {BANK_BASE_HI, $past(bank_in), op_reg[2:0]})
        else $error("bank register source read at wrong address");

    AST_ILLEGAL_REJECT: assert property (
        take && (opcode_in == 8'h60 || opcode_in == 8'h61) |-> illegal_out ##1 idle)
        else $error("unsupported xor form accepted");

    AST_XD_LATCH_READ: assert property (
        take && opcode_in == OPC_XD_IMM |=> mem_rd_out && mem_latch_out
            ##1 !mem_latch_out)
        else $error("port destination not read from latch");

    AST_XD_MASK: assert property (
        exec && is_xd_imm |=> mem_wr_out && mem_addr_out == $past(dir_reg)
            && mem_wdata_out == ($past(mem_rdata_in) ^ $past(imm_reg)))
        else $error("direct destination mask not applied");

    AST_PTR_SELECT: assert property (
        take && legal && (opcode_in[7:1] == OPC_EXDIG_HI)
            |=> mem_addr_out == {BANK_BASE_HI, $past(bank_in), 2'b00, $past(opcode_in[0])}
            ##1 mem_indirect_out ##1 exec ##1 mem_wr_out)
        else $error("wrong pointer register for exchange_digit");

    COV_EXDIG: cover property (exec && is_exdig ##1 mem_wr_out);
    COV_XA_IMM: cover property (take && opcode_in == OPC_XA_IMM ##1 done_out);
    COV_XD_ACC: cover property (exec && is_xd_acc ##1 mem_wr_out);
    COV_ILLEGAL: cover property (illegal_out);

endmodule : nxa_datapath // nxa_datapath

`default_nettype wire

// file: pkg/nxa_pkg.sv
// Purpose: constants for the nibble-exchange / exclusive-or datapath
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: opcodes are the one-byte instruction codes seen on opcode_in
//
// Operation
// - exchange_digit swaps accumulator bits 3..0 with bits 3..0 of the RAM byte addressed by the pointer_register.
// - exchange_digit leaves bits 7..4 of the accumulator and of the RAM byte as they were and changes no status flag.
// - xor_bytes writes the bitwise exclusive-or of its two byte operands back into the destination.
// - no form of xor_bytes changes any status flag, carry, auxiliary carry and overflow included.
// - with the accumulator as destination the source is a bank register, a direct byte, an indirect RAM byte or a constant.
// - with a direct byte as destination the source is only the accumulator or a constant.
// - a port destination takes its original value from the output data latch, not from the pins.
// - a direct destination has exactly the bits set in the mask (constant or accumulator) inverted.
`default_nettype none

package nxa_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [6:0] OPC_EXDIG_HI = 7'h6B;  // 1101_011i
    localparam logic [4:0] OPC_XA_REG_HI = 5'h0D;  // 0110_1rrr
    localparam logic [6:0] OPC_XA_IND_HI = 7'h33;  // 0110_011i
    localparam logic [7:0] OPC_XA_DIR = 8'h65;
    localparam logic [7:0] OPC_XA_IMM = 8'h64;
    localparam logic [7:0] OPC_XD_ACC = 8'h62;
    localparam logic [7:0] OPC_XD_IMM = 8'h63;

    // ----------------------------------------------------------------
    // reset values and address layout
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [2:0] BANK_BASE_HI = 3'h0;  // bank registers live at 00..1F

    typedef enum logic [1:0] {
        NXA_KIND_EXDIG,
        NXA_KIND_XOR_ACC,
        NXA_KIND_XOR_DIR
    } nxa_kind_t;

endpackage : nxa_pkg

`default_nettype wire

// file: hdl/nxa_alu_core.sv
// Purpose: combinational result logic for exchange_digit and xor_bytes
// Assumes: operands already selected by the sequencer
// Notes: no flag outputs exist, so status can never be disturbed here
`default_nettype none

module nxa_alu_core
    import nxa_pkg::*;
(
    // operation
    input wire nxa_kind_t kind_in,
    // operands
    input wire logic [7:0] acc_in,
    input wire logic [7:0] mem_in,
    input wire logic [7:0] src_in,
    // results
    output logic [7:0] acc_new_out,
    output logic [7:0] mem_new_out
);

    // --------------------------------------------------------------
    // results
    // --------------------------------------------------------------
    wire logic [7:0] exdig_acc = {acc_in[7:4], mem_in[3:0]};
    wire logic [7:0] exdig_mem = {mem_in[7:4], acc_in[3:0]};

    assign acc_new_out = (kind_in == NXA_KIND_EXDIG) ? exdig_acc :
                         (kind_in == NXA_KIND_XOR_ACC) ? (acc_in ^ src_in) : acc_in;
    assign mem_new_out = (kind_in == NXA_KIND_EXDIG) ? exdig_mem : (mem_in ^ src_in);

endmodule : nxa_alu_core // nxa_alu_core

`default_nettype wire

// file: test/nibble_exchange_xor_alu_tb_top.sv
// Purpose: self-checking bench for the exchange_digit / xor_bytes datapath
// Assumes: memory answers one cycle after a read strobe
// Notes: direct reads of 80..FF show pin levels unless the latch is asked for
`default_nettype none
module nibble_exchange_xor_alu_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import nxa_pkg::*;

    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic start_in = 1'b0;
    logic [7:0] opcode_in = 8'h00;
    logic [7:0] operand1_in = 8'h00;
    logic [7:0] operand2_in = 8'h00;
    logic [1:0] bank_in = 2'h0;
    logic acc_load_in = 1'b0;
    logic [7:0] acc_data_in = 8'h00;
    logic [7:0] mem_rdata_in = 8'h00;
    logic mem_rd_out, mem_wr_out, mem_indirect_out, mem_latch_out;
    logic busy_out, done_out, illegal_out;
    logic [7:0] mem_addr_out, mem_wdata_out, acc_out;
    logic [7:0] mem [256];
    logic [7:0] m_acc = 8'h00;
    logic [7:0] q_acc[$], q_wa[$], q_wd[$];
    logic done_d = 1'b0;
    int errors = 0;
    int n_compared = 0;
    logic [7:0] opc_tab [16] = '{8'hD6, 8'hD7, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
        8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F};

    always #50 ref_clk_in = ~ref_clk_in;

    nxa_datapath i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .start_in(start_in),
        .opcode_in(opcode_in), .operand1_in(operand1_in), .operand2_in(operand2_in),
        .bank_in(bank_in), .acc_load_in(acc_load_in), .acc_data_in(acc_data_in),
        .mem_rdata_in(mem_rdata_in), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_addr_out(mem_addr_out), .mem_indirect_out(mem_indirect_out),
        .mem_latch_out(mem_latch_out), .mem_wdata_out(mem_wdata_out), .busy_out(busy_out),
        .done_out(done_out), .illegal_out(illegal_out), .acc_out(acc_out));

    // ----------------------------------------------------------------
    // checks and reporting
    // ----------------------------------------------------------------
    // pins differ from the latch so a wrong source shows up
    function automatic logic [7:0] pin(input logic [7:0] a);
        return a[7] ? (mem[a] ^ 8'h5A) : mem[a];
    endfunction

    task automatic cmp_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input string what, input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // memory model and result monitor
    // ----------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        done_d <= done_out;
        if (mem_rd_out === 1'b1)
            // indirect reads reach RAM, so a missing indirect flag shows as pin data
            mem_rdata_in <= (mem_latch_out === 1'b1 || mem_indirect_out === 1'b1) ?
                mem[mem_addr_out] : pin(mem_addr_out);
        else
            mem_rdata_in <= ~mem_rdata_in;
        if (mem_wr_out === 1'b1 && q_wa.size() > 0) begin
            cmp_byte("write address", mem_addr_out, q_wa[0]);
            cmp_byte("write data", mem_wdata_out, q_wd[0]);
            mem[q_wa[0]] <= q_wd[0];
            void'(q_wa.pop_front());
            void'(q_wd.pop_front());
        end else if (mem_wr_out === 1'b1) begin
            cmp_bit("write strobe", mem_wr_out, 1'b0);
        end
        if (done_d === 1'b1 && q_acc.size() > 0)
            cmp_byte("accumulator", acc_out, q_acc.pop_front());
    end

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic run_op(input logic [7:0] opc, o1, o2, input logic junk);
        logic [7:0] ptr, b;
        int k;
        ptr = mem[{3'h0, bank_in, 2'b00, opc[0]}];
        b = mem[ptr];
        case (opc) inside
            8'hD6, 8'hD7: begin
                q_wa.push_back(ptr);
                q_wd.push_back({b[7:4], m_acc[3:0]});
                m_acc = {m_acc[7:4], b[3:0]};
            end
            8'h62: begin q_wa.push_back(o1); q_wd.push_back(mem[o1] ^ m_acc); end
            8'h63: begin q_wa.push_back(o1); q_wd.push_back(mem[o1] ^ o2); end
            8'h64: m_acc = m_acc ^ o1;
            8'h65: m_acc = m_acc ^ pin(o1);
            8'h66, 8'h67: m_acc = m_acc ^ b;
            default: m_acc = m_acc ^ mem[{3'h0, bank_in, opc[2:0]}];
        endcase
        q_acc.push_back(m_acc);
        start_in <= 1'b1;
        opcode_in <= opc;
        operand1_in <= o1;
        operand2_in <= o2;
        @(posedge ref_clk_in);
        // a second request while busy must be ignored
        start_in <= junk;
        opcode_in <= 8'h64;
        for (k = 0; k < 20; k++) begin
            #1;
            if (done_out === 1'b1) break;
            @(posedge ref_clk_in);
            start_in <= 1'b0;
        end
        if (k == 20) begin
            errors++;
            $display("unexpected at %0t: no completion", $time);
            stop_test();
        end
        @(posedge ref_clk_in);
    endtask

    task automatic try_illegal(input logic [7:0] opc);
        start_in <= 1'b1;
        opcode_in <= opc;
        #1;
        cmp_bit("illegal flag", illegal_out, 1'b1);
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        #1;
        cmp_bit("busy after illegal", busy_out, 1'b0);
        @(posedge ref_clk_in);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] opc;
        void'($urandom(36072));
        for (int i = 0; i < 256; i++)
            mem[i] = 8'($urandom);
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        #1;
        cmp_byte("reset accumulator", acc_out, ACC_RESET);
        @(posedge ref_clk_in);
        // worked exchange example: pointer 20, acc 36, byte 75
        mem[8'h00] = 8'h20;
        mem[8'h20] = 8'h75;
        acc_load_in <= 1'b1;
        acc_data_in <= 8'h36;
        @(posedge ref_clk_in);
        acc_load_in <= 1'b0;
        m_acc = 8'h36;
        run_op(8'hD6, 8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 64; i++) begin
            opc = opc_tab[i % 16];
            bank_in <= 2'($urandom);
            @(posedge ref_clk_in);
            if (i % 5 == 0) begin
                acc_load_in <= 1'b1;
                acc_data_in <= 8'($urandom);
                @(posedge ref_clk_in);
                acc_load_in <= 1'b0;
                m_acc = acc_data_in;
            end
            run_op(opc, 8'($urandom), 8'($urandom), (opc != 8'h64) && $urandom % 2 == 1);
        end
        foreach (opc_tab[i])
            if (i < 5) try_illegal(i == 0 ? 8'h60 : i == 1 ? 8'h61 : i == 2 ? 8'h00 :
                i == 3 ? 8'hD5 : 8'hFF);
        repeat (2) @(posedge ref_clk_in);
        cmp_byte("pending notes", 8'(q_acc.size() + q_wa.size()), 8'h00);
        stop_test();
    end
endmodule // nibble_exchange_xor_alu_tb_top
`default_nettype wire
